// ===== inc/rrs_consts.svh
// Constants for the return, rotate and sleep execution block.
`ifndef RRS_CONSTS_SVH
`define RRS_CONSTS_SVH
`define RRS_DATA_W 8
`define RRS_ADDR_W 7
`define RRS_PC_W 13
`define RRS_WDT_W 8
`define RRS_PRE_W 8
`define RRS_DEST_ACC 1'b0
`define RRS_DEST_FILE 1'b1
`define RRS_PD_RESET 1'b1
`define RRS_TO_RESET 1'b1
`define RRS_CARRY_RESET 1'b0
`define RRS_WDT_CLEAR 8'h00
`define RRS_PRE_CLEAR 8'h00
`endif

// ===== inc/rrs_pkg.sv
// Types for the return, rotate and sleep execution block.
package rrs_pkg;
  typedef enum logic [1:0] {
    RRS_OP_RETURN = 2'b00,
    RRS_OP_ROTL = 2'b01,
    RRS_OP_ROTR = 2'b10,
    RRS_OP_SLEEP = 2'b11
  } rrs_op_t;
  typedef enum logic [1:0] {
    RRS_ST_EXEC = 2'b00,
    RRS_ST_RET2 = 2'b01,
    RRS_ST_SLEEP = 2'b10
  } rrs_state_t;
endpackage

// ===== rtl/rrs_rotate.sv
// Rotate-through-carry unit for one data byte.
`timescale 1ns/10ps
`include "rrs_consts.svh"
module rrs_rotate (
  input wire logic dir_right,
  input wire logic [`RRS_DATA_W-1:0] din,
  input wire logic cin,
  output logic [`RRS_DATA_W-1:0] dout,
  output logic cout
);
  always_comb begin
    if (dir_right) begin
      dout = {cin, din[`RRS_DATA_W-1:1]}; // [RULE4] [RULE10]
      cout = din[0]; // [RULE10]
    end else begin
      dout = {din[`RRS_DATA_W-2:0], cin}; // [RULE2] [RULE10]
      cout = din[`RRS_DATA_W-1]; // [RULE10]
    end
  end
endmodule

// ===== rtl/rrs_exec.sv
// Execution of return, rotate-left, rotate-right and sleep instructions.
`timescale 1ns/10ps
`include "rrs_consts.svh"
// Contract
// [RULE1] Return pops stack into PC, two cycles.
// [RULE2] Rotate left addressed register through carry.
// [RULE3] Rotate left: dest 0 accumulator, 1 register.
// [RULE4] Rotate right addressed register through carry.
// [RULE5] Rotate right: dest 0 accumulator, 1 register.
// [RULE6] Sleep clears the power-down flag.
// [RULE7] Sleep sets the watchdog expiry flag.
// [RULE8] Sleep clears watchdog counter and prescaler.
// [RULE9] Sleep halts with the oscillator stopped.
// [RULE10] Carry enters vacated bit; leaving bit becomes carry.
module rrs_exec (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic instr_valid,
  input wire rrs_pkg::rrs_op_t instr_op,
  input wire logic [`RRS_ADDR_W-1:0] instr_addr,
  input wire logic instr_dest,
  input wire logic [`RRS_DATA_W-1:0] reg_rdata,
  input wire logic [`RRS_PC_W-1:0] stack_top_entry,
  input wire logic wdt_tick,
  input wire logic wake_req,
  output logic busy_reg,
  output logic stack_pop_reg,
  output logic pc_load_reg,
  output logic [`RRS_PC_W-1:0] pc_value_reg,
  output logic acc_we_reg,
  output logic [`RRS_DATA_W-1:0] acc_wdata_reg,
  output logic file_we_reg,
  output logic [`RRS_ADDR_W-1:0] file_addr_reg,
  output logic [`RRS_DATA_W-1:0] file_wdata_reg,
  output logic carry_flag_reg,
  output logic power_down_flag_reg,
  output logic watchdog_expiry_flag_reg,
  output logic [`RRS_WDT_W-1:0] watchdog_counter_reg,
  output logic [`RRS_PRE_W-1:0] wdt_prescaler_reg,
  output logic osc_run_reg,
  output logic sleeping_reg
);
  rrs_pkg::rrs_state_t state_reg;
  rrs_pkg::rrs_state_t state_next;
  logic busy_next;
  logic stack_pop_next;
  logic pc_load_next;
  logic [`RRS_PC_W-1:0] pc_value_next;
  logic acc_we_next;
  logic [`RRS_DATA_W-1:0] acc_wdata_next;
  logic file_we_next;
  logic [`RRS_ADDR_W-1:0] file_addr_next;
  logic [`RRS_DATA_W-1:0] file_wdata_next;
  logic carry_flag_next;
  logic power_down_flag_next;
  logic watchdog_expiry_flag_next;
  logic [`RRS_WDT_W-1:0] watchdog_counter_next;
  logic [`RRS_PRE_W-1:0] wdt_prescaler_next;
  logic osc_run_next;
  logic sleeping_next;
  logic accept;
  logic [`RRS_DATA_W-1:0] rot_data;
  logic rot_carry;

  // Both rotate opcodes share one datapath; only the direction differs.
  function automatic logic is_rotate(input rrs_pkg::rrs_op_t op);
    is_rotate = (op == rrs_pkg::RRS_OP_ROTL) || (op == rrs_pkg::RRS_OP_ROTR);
  endfunction

  // Instructions are only taken in the execute state, so the second return
  // cycle and sleep both hold off the issuing stage.
  assign accept = instr_valid && (state_reg == rrs_pkg::RRS_ST_EXEC);

  rrs_rotate u_rotate (
    .dir_right(instr_op == rrs_pkg::RRS_OP_ROTR),
    .din(reg_rdata),
    .cin(carry_flag_reg),
    .dout(rot_data),
    .cout(rot_carry)
  );

  always_comb begin
    state_next = state_reg;
    busy_next = 1'b0;
    stack_pop_next = 1'b0;
    pc_load_next = 1'b0;
    pc_value_next = pc_value_reg;
    acc_we_next = 1'b0;
    acc_wdata_next = acc_wdata_reg;
    file_we_next = 1'b0;
    file_addr_next = file_addr_reg;
    file_wdata_next = file_wdata_reg;
    carry_flag_next = carry_flag_reg;
    power_down_flag_next = power_down_flag_reg;
    watchdog_expiry_flag_next = watchdog_expiry_flag_reg;
    osc_run_next = osc_run_reg;
    sleeping_next = sleeping_reg;
    unique case (state_reg)
      rrs_pkg::RRS_ST_EXEC: begin
        if (accept) begin
          if (instr_op == rrs_pkg::RRS_OP_RETURN) begin
            stack_pop_next = 1'b1; // [RULE1]
            pc_load_next = 1'b1; // [RULE1]
            pc_value_next = stack_top_entry; // [RULE1]
            busy_next = 1'b1; // [RULE1]
            state_next = rrs_pkg::RRS_ST_RET2; // [RULE1]
          end else if (is_rotate(instr_op)) begin
            carry_flag_next = rot_carry; // [RULE10]
            if (instr_dest == `RRS_DEST_ACC) begin
              acc_we_next = 1'b1; // [RULE3] [RULE5]
              acc_wdata_next = rot_data; // [RULE3] [RULE5]
            end else begin
              file_we_next = 1'b1; // [RULE3] [RULE5]
              file_addr_next = instr_addr; // [RULE2] [RULE4]
              file_wdata_next = rot_data; // [RULE3] [RULE5]
            end
          end else begin
            power_down_flag_next = 1'b0; // [RULE6]
            watchdog_expiry_flag_next = 1'b1; // [RULE7]
            osc_run_next = 1'b0; // [RULE9]
            sleeping_next = 1'b1; // [RULE9]
            state_next = rrs_pkg::RRS_ST_SLEEP; // [RULE9]
          end
        end
      end
      rrs_pkg::RRS_ST_RET2: begin
        state_next = rrs_pkg::RRS_ST_EXEC;
      end
      rrs_pkg::RRS_ST_SLEEP: begin
        if (wake_req) begin
          osc_run_next = 1'b1;
          sleeping_next = 1'b0;
          state_next = rrs_pkg::RRS_ST_EXEC;
        end
      end
      default: begin
        state_next = rrs_pkg::RRS_ST_EXEC;
      end
    endcase
  end

  // The watchdog runs from its own tick even during sleep; a sleep entry in
  // the same cycle as a tick wins, so the count always restarts from zero.
  always_comb begin
    watchdog_counter_next = watchdog_counter_reg;
    wdt_prescaler_next = wdt_prescaler_reg;
    if (accept && (instr_op == rrs_pkg::RRS_OP_SLEEP)) begin
      watchdog_counter_next = `RRS_WDT_CLEAR; // [RULE8]
      wdt_prescaler_next = `RRS_PRE_CLEAR; // [RULE8]
    end else if (wdt_tick) begin
      wdt_prescaler_next = wdt_prescaler_reg + 8'h01;
      if (wdt_prescaler_reg == 8'hff) begin
        watchdog_counter_next = watchdog_counter_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= rrs_pkg::RRS_ST_EXEC;
      busy_reg <= 1'b0;
      stack_pop_reg <= 1'b0;
      pc_load_reg <= 1'b0;
      pc_value_reg <= 13'h0000;
      acc_we_reg <= 1'b0;
      acc_wdata_reg <= 8'h00;
      file_we_reg <= 1'b0;
      file_addr_reg <= 7'h00;
      file_wdata_reg <= 8'h00;
      carry_flag_reg <= `RRS_CARRY_RESET;
      power_down_flag_reg <= `RRS_PD_RESET;
      watchdog_expiry_flag_reg <= `RRS_TO_RESET;
      watchdog_counter_reg <= `RRS_WDT_CLEAR;
      wdt_prescaler_reg <= `RRS_PRE_CLEAR;
      osc_run_reg <= 1'b1;
      sleeping_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy_reg <= busy_next;
      stack_pop_reg <= stack_pop_next;
      pc_load_reg <= pc_load_next;
      pc_value_reg <= pc_value_next;
      acc_we_reg <= acc_we_next;
      acc_wdata_reg <= acc_wdata_next;
      file_we_reg <= file_we_next;
      file_addr_reg <= file_addr_next;
      file_wdata_reg <= file_wdata_next;
      carry_flag_reg <= carry_flag_next;
      power_down_flag_reg <= power_down_flag_next;
      watchdog_expiry_flag_reg <= watchdog_expiry_flag_next;
      watchdog_counter_reg <= watchdog_counter_next;
      wdt_prescaler_reg <= wdt_prescaler_next;
      osc_run_reg <= osc_run_next;
      sleeping_reg <= sleeping_next;
    end
  end

  ret_pop_a: assert property (@(posedge clk_sys) disable iff (srst) // [RULE1]
    accept && instr_op == rrs_pkg::RRS_OP_RETURN |=> stack_pop_reg && pc_load_reg
      && pc_value_reg == $past(stack_top_entry))
    else $error("Return did not load the popped stack entry.");

  ret_two_cycle_a: assert property (@(posedge clk_sys) disable iff (srst) // [RULE1]
    accept && instr_op == rrs_pkg::RRS_OP_RETURN |=> !accept && busy_reg ##1
      state_reg == rrs_pkg::RRS_ST_EXEC && !stack_pop_reg && !busy_reg)
    else $error("Return did not take exactly two cycles.");

  rotl_acc_a: assert property (@(posedge clk_sys) disable iff (srst) // [RULE3]
    accept && instr_op == rrs_pkg::RRS_OP_ROTL && instr_dest == 1'b0 |=> acc_we_reg && !file_we_reg
      && acc_wdata_reg == {$past(reg_rdata[6:0]), $past(carry_flag_reg)})
    else $error("Rotate left to accumulator gave a wrong result.");

  rotl_file_a: assert property (@(posedge clk_sys) disable iff (srst) // [RULE2]
    accept && instr_op == rrs_pkg::RRS_OP_ROTL && instr_dest == 1'b1 |=> file_we_reg && !acc_we_reg
      && file_addr_reg == $past(instr_addr) && carry_flag_reg == $past(reg_rdata[7])
      && file_wdata_reg == {$past(reg_rdata[6:0]), $past(carry_flag_reg)})
    else $error("Rotate left back to register went wrong.");

  rotr_acc_a: assert property (@(posedge clk_sys) disable iff (srst) // [RULE5]
    accept && instr_op == rrs_pkg::RRS_OP_ROTR && instr_dest == 1'b0 |=> acc_we_reg && !file_we_reg
      && acc_wdata_reg == {$past(carry_flag_reg), $past(reg_rdata[7:1])})
    else $error("Rotate right to accumulator gave a wrong result.");

  rotr_file_a: assert property (@(posedge clk_sys) disable iff (srst) // [RULE4]
    accept && instr_op == rrs_pkg::RRS_OP_ROTR && instr_dest == 1'b1 |=> file_we_reg
      && file_wdata_reg == {$past(carry_flag_reg), $past(reg_rdata[7:1])}
      && carry_flag_reg == $past(reg_rdata[0]))
    else $error("Rotate right back to register went wrong.");

  sleep_flags_a: assert property (@(posedge clk_sys) disable iff (srst) // [RULE6]
    accept && instr_op == rrs_pkg::RRS_OP_SLEEP |=> !power_down_flag_reg && watchdog_expiry_flag_reg)
    else $error("Sleep did not update the power-down flag.");

  sleep_expiry_a: assert property (@(posedge clk_sys) disable iff (srst) // [RULE7]
    accept && instr_op == rrs_pkg::RRS_OP_SLEEP |=> watchdog_expiry_flag_reg)
    else $error("Sleep did not set the watchdog expiry flag.");

  sleep_wdt_a: assert property (@(posedge clk_sys) disable iff (srst) // [RULE8]
    accept && instr_op == rrs_pkg::RRS_OP_SLEEP |=> watchdog_counter_reg == 8'h00 && wdt_prescaler_reg == 8'h00)
    else $error("Sleep did not clear the watchdog.");

  sleep_halt_a: assert property (@(posedge clk_sys) disable iff (srst) // [RULE9]
    accept && instr_op == rrs_pkg::RRS_OP_SLEEP && !wake_req |=> sleeping_reg && !osc_run_reg
      ##1 (!wake_req || $past(wake_req)) |-> !osc_run_reg || $past(wake_req))
    else $error("Sleep did not halt with the oscillator stopped.");

  sleep_stay_a: assert property (@(posedge clk_sys) disable iff (srst) // [RULE9]
    sleeping_reg && !wake_req |=> sleeping_reg && !osc_run_reg && !acc_we_reg && !file_we_reg)
    else $error("Sleep was left or work was done without a wake request.");

  carry_hold_a: assert property (@(posedge clk_sys) disable iff (srst) // [RULE10]
    !(accept && is_rotate(instr_op)) |=> $stable(carry_flag_reg))
    else $error("Carry changed without a rotate.");
endmodule

// ===== tb/test_return_rotate_sleep_exec.sv
// Self-checking testbench for the return, rotate and sleep execution block.
`timescale 1ns/10ps
`include "rrs_consts.svh"
module test_return_rotate_sleep_exec;
  logic clk_sys = 1'b0, srst = 1'b1, instr_valid = 1'b0, instr_dest = 1'b0, wdt_tick = 1'b0, wake_req = 1'b0;
  rrs_pkg::rrs_op_t instr_op = rrs_pkg::RRS_OP_ROTL;
  logic [6:0] instr_addr = 7'h00;
  logic [7:0] reg_rdata = 8'h00;
  logic [12:0] stack_top_entry = 13'h0000;
  logic busy_reg, stack_pop_reg, pc_load_reg, acc_we_reg, file_we_reg, carry_flag_reg;
  logic power_down_flag_reg, watchdog_expiry_flag_reg, osc_run_reg, sleeping_reg;
  logic [12:0] pc_value_reg;
  logic [7:0] acc_wdata_reg, file_wdata_reg, watchdog_counter_reg, wdt_prescaler_reg;
  logic [6:0] file_addr_reg;
  logic exp_c = 1'b0;
  int mismatches = 0, cmp_count = 0, cycles = 0;

  rrs_exec u_dut (.clk_sys(clk_sys), .srst(srst), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_addr(instr_addr), .instr_dest(instr_dest), .reg_rdata(reg_rdata), .stack_top_entry(stack_top_entry),
    .wdt_tick(wdt_tick), .wake_req(wake_req), .busy_reg(busy_reg), .stack_pop_reg(stack_pop_reg),
    .pc_load_reg(pc_load_reg), .pc_value_reg(pc_value_reg), .acc_we_reg(acc_we_reg), .acc_wdata_reg(acc_wdata_reg),
    .file_we_reg(file_we_reg), .file_addr_reg(file_addr_reg), .file_wdata_reg(file_wdata_reg),
    .carry_flag_reg(carry_flag_reg), .power_down_flag_reg(power_down_flag_reg),
    .watchdog_expiry_flag_reg(watchdog_expiry_flag_reg), .watchdog_counter_reg(watchdog_counter_reg),
    .wdt_prescaler_reg(wdt_prescaler_reg), .osc_run_reg(osc_run_reg), .sleeping_reg(sleeping_reg));

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // A hung handshake would otherwise stall the run forever.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic put(input rrs_pkg::rrs_op_t op, input logic [6:0] a, input logic d, input logic [7:0] din);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_addr <= a;
    instr_dest <= d;
    reg_rdata <= din;
  endtask

  // The expected carry chains from one rotate to the next, so order of calls matters.
  task automatic chk_rot(input logic r, input logic [6:0] a, input logic d, input logic [7:0] din);
    logic [7:0] res;
    res = r ? {exp_c, din[7:1]} : {din[6:0], exp_c};
    exp_c = r ? din[0] : din[7];
    chk("acc_we", 16'(!d), 16'(acc_we_reg));
    chk("file_we", 16'(d), 16'(file_we_reg));
    if (d) begin
      chk("file_addr", 16'(a), 16'(file_addr_reg));
      chk("file_wdata", 16'(res), 16'(file_wdata_reg));
    end else begin
      chk("acc_wdata", 16'(res), 16'(acc_wdata_reg));
    end
    chk("carry", 16'(exp_c), 16'(carry_flag_reg));
  endtask

  task automatic rot(input rrs_pkg::rrs_op_t op, input logic [6:0] a, input logic d, input logic [7:0] din);
    @(posedge clk_sys);
    put(op, a, d, din);
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
    chk_rot(op == rrs_pkg::RRS_OP_ROTR, a, d, din);
  endtask

  task automatic test_return();
    @(posedge clk_sys);
    put(rrs_pkg::RRS_OP_RETURN, 7'h00, 1'b0, 8'h00);
    stack_top_entry <= 13'h1abc;
    @(posedge clk_sys);
    put(rrs_pkg::RRS_OP_ROTL, 7'h11, 1'b0, 8'hff);
    stack_top_entry <= 13'h0555;
    #1;
    chk("pop", 16'h0001, 16'(stack_pop_reg));
    chk("pc_load", 16'h0001, 16'(pc_load_reg));
    chk("busy", 16'h0001, 16'(busy_reg));
    chk("pc_value", 16'h1abc, 16'(pc_value_reg));
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
    chk("pop", 16'h0000, 16'(stack_pop_reg));
    chk("busy", 16'h0000, 16'(busy_reg));
    chk("acc_we", 16'h0000, 16'(acc_we_reg));
    chk("pc_value", 16'h1abc, 16'(pc_value_reg));
  endtask

  task automatic test_rotates();
    rot(rrs_pkg::RRS_OP_ROTL, 7'h00, `RRS_DEST_ACC, 8'he6);
    rot(rrs_pkg::RRS_OP_ROTR, 7'h7f, `RRS_DEST_FILE, 8'h01);
    rot(rrs_pkg::RRS_OP_ROTL, 7'h05, `RRS_DEST_FILE, 8'h80);
    rot(rrs_pkg::RRS_OP_ROTR, 7'h40, `RRS_DEST_ACC, 8'h02);
    @(posedge clk_sys);
    put(rrs_pkg::RRS_OP_ROTL, 7'h03, `RRS_DEST_FILE, 8'h7f);
    @(posedge clk_sys);
    put(rrs_pkg::RRS_OP_ROTR, 7'h09, `RRS_DEST_ACC, 8'h55);
    #1;
    chk_rot(1'b0, 7'h03, `RRS_DEST_FILE, 8'h7f);
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
    chk_rot(1'b1, 7'h09, `RRS_DEST_ACC, 8'h55);
  endtask

  task automatic test_sleep();
    repeat (300) begin
      @(posedge clk_sys);
      wdt_tick <= 1'b1;
    end
    @(posedge clk_sys);
    put(rrs_pkg::RRS_OP_SLEEP, 7'h00, 1'b0, 8'h00);
    #1;
    chk("prescaler", 16'h002c, 16'(wdt_prescaler_reg));
    chk("wdt", 16'h0001, 16'(watchdog_counter_reg));
    @(posedge clk_sys);
    wdt_tick <= 1'b0;
    put(rrs_pkg::RRS_OP_ROTL, 7'h01, `RRS_DEST_ACC, 8'h81);
    #1;
    chk("power_down", 16'h0000, 16'(power_down_flag_reg));
    chk("expiry", 16'h0001, 16'(watchdog_expiry_flag_reg));
    chk("wdt", 16'(`RRS_WDT_CLEAR), 16'(watchdog_counter_reg));
    chk("prescaler", 16'(`RRS_PRE_CLEAR), 16'(wdt_prescaler_reg));
    chk("osc_run", 16'h0000, 16'(osc_run_reg));
    chk("sleeping", 16'h0001, 16'(sleeping_reg));
    repeat (3) @(posedge clk_sys);
    wake_req <= 1'b1;
    instr_valid <= 1'b0;
    #1;
    chk("acc_we", 16'h0000, 16'(acc_we_reg));
    chk("carry", 16'(exp_c), 16'(carry_flag_reg));
    @(posedge clk_sys);
    wake_req <= 1'b0;
    #1;
    chk("osc_run", 16'h0001, 16'(osc_run_reg));
    chk("sleeping", 16'h0000, 16'(sleeping_reg));
    chk("power_down", 16'h0000, 16'(power_down_flag_reg));
    rot(rrs_pkg::RRS_OP_ROTR, 7'h7f, `RRS_DEST_FILE, 8'hc3);
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    chk("power_down", 16'(`RRS_PD_RESET), 16'(power_down_flag_reg));
    chk("expiry", 16'(`RRS_TO_RESET), 16'(watchdog_expiry_flag_reg));
    chk("osc_run", 16'h0001, 16'(osc_run_reg));
    chk("carry", 16'(`RRS_CARRY_RESET), 16'(carry_flag_reg));
    test_return();
    test_rotates();
    test_return();
    test_sleep();
    stop_test();
  end
endmodule
